// ===== rtl/ses_defs.svh
`ifndef SES_DEFS_SVH
`define SES_DEFS_SVH
// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define SES_A_STD_COND  8'h00
`define SES_A_STD_EVT   8'h04
`define SES_A_STD_ENA   8'h08
`define SES_A_OPR_COND  8'h10
`define SES_A_OPR_EVT   8'h14
`define SES_A_OPR_ENA   8'h18
`define SES_A_MEA_COND  8'h20
`define SES_A_MEA_EVT   8'h24
`define SES_A_MEA_ENA   8'h28
`define SES_A_QUE_COND  8'h30
`define SES_A_QUE_EVT   8'h34
`define SES_A_QUE_ENA   8'h38
`define SES_A_STB       8'h40
`define SES_A_SRE       8'h44
`define SES_A_CMD       8'h48
`define SES_A_ERRQ      8'h4C
`define SES_A_OUTQ      8'h50
`define SES_A_LEVEL     8'h54
`define SES_A_POLL      8'h58
// ----------------------------------------------------------------
// Command bits written to the command register
// ----------------------------------------------------------------
`define SES_CMD_CLS     0
`define SES_CMD_PRESET  1
`define SES_CMD_ERRCLR  2
`define SES_CMD_RST     3
// ----------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------
`define SES_SB_MEA      0
`define SES_SB_EAV      2
`define SES_SB_QUE      3
`define SES_SB_MAV      4
`define SES_SB_STD      5
`define SES_SB_REQ      6
`define SES_SB_OPR      7
// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define SES_QDEPTH      8
`define SES_QAW         3
`define SES_ZERO16      16'h0000
`define SES_ZERO32      32'h0000_0000
`endif

// ===== rtl/ses_pkg.sv
`default_nettype none
package ses_pkg;
    // Index of each register set
    typedef enum logic [1:0] {
        SES_STD = 2'h0,
        SES_OPR = 2'h1,
        SES_MEA = 2'h2,
        SES_QUE = 2'h3
    } ses_set_t;
    // AHB address phase capture
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } ses_req_t;
    // Queue occupancy count with pointers
    typedef struct packed {
        logic [3:0] count;
        logic [2:0] rptr;
        logic [2:0] wptr;
    } ses_qptr_t;
endpackage
`default_nettype wire

// ===== rtl/ses_status.sv
`include "ses_defs.svh"
`default_nettype none
module ses_status
    import ses_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Instrument side
    input  wire logic [63:0] cond_in,
    input  wire logic [63:0] evt_pulse,
    input  wire logic        err_push,
    input  wire logic [15:0] err_code,
    input  wire logic        resp_push,
    input  wire logic [15:0] resp_data,
    // Status outputs
    output logic [7:0]       status_byte,
    output logic             srq
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [63:0] cond_s1, cond_s2, evt_s1, evt_s2, evt_s3;
    // Two flops before any logic reads the pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cond_s1 <= 64'h0000_0000_0000_0000;
            cond_s2 <= 64'h0000_0000_0000_0000;
            evt_s1  <= 64'h0000_0000_0000_0000;
            evt_s2  <= 64'h0000_0000_0000_0000;
            evt_s3  <= 64'h0000_0000_0000_0000;
        end else begin
            cond_s1 <= cond_in;
            cond_s2 <= cond_s1;
            evt_s1  <= evt_pulse;
            evt_s2  <= evt_s1;
            evt_s3  <= evt_s2;
        end
    end
    // Rising edge of a synchronised event line
    logic [63:0] evt_set;
    assign evt_set = evt_s2 & ~evt_s3;
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    ses_req_t req;
    logic     acc;
    assign acc       = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (hready) begin
            req.wr   <= acc & hwrite;
            req.rd   <= acc & ~hwrite;
            req.addr <= haddr[7:0];
        end
    end
    logic        cmd_wr;
    logic        cls, preset, errclr;
    assign cmd_wr = req.wr && req.addr == `SES_A_CMD;
    assign cls    = cmd_wr & hwdata[`SES_CMD_CLS];
    assign preset = cmd_wr & hwdata[`SES_CMD_PRESET];
    // Instrument reset bit is accepted and deliberately has no effect
    assign errclr = cmd_wr & (hwdata[`SES_CMD_ERRCLR] | hwdata[`SES_CMD_CLS]);
    // ----------------------------------------------------------------
    // Register sets
    // ----------------------------------------------------------------
    logic [15:0] evt [4];
    logic [15:0] ena [4];
    logic [3:0]  set_sum;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_set
            logic [7:0] a_evt, a_ena;
            logic       evt_rd, ena_wr;
            assign a_evt  = `SES_A_STD_EVT + 8'(g * 16);
            assign a_ena  = `SES_A_STD_ENA + 8'(g * 16);
            assign evt_rd = req.rd && req.addr == a_evt;
            assign ena_wr = req.wr && req.addr == a_ena;
            // Latching events; new set wins over read or clear
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    evt[g] <= `SES_ZERO16;
                end else begin
                    evt[g] <= ((evt_rd | cls) ? `SES_ZERO16 : evt[g]) | evt_set[g*16 +: 16];
                end
            end
            // Enable registers, host writable; preset clears all but the standard set
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ena[g] <= `SES_ZERO16;
                end else if (ena_wr) begin
                    ena[g] <= hwdata[15:0];
                end else if (preset && g != 0) begin
                    ena[g] <= `SES_ZERO16;
                end
            end
            // Summary output
            assign set_sum[g] = |(evt[g] & ena[g]);
        end
    endgenerate
    // ----------------------------------------------------------------
    // Queues
    // ----------------------------------------------------------------
    logic [15:0] eq_mem [`SES_QDEPTH];
    logic [15:0] oq_mem [`SES_QDEPTH];
    ses_qptr_t   eq, oq;
    logic        eq_pop, oq_pop, eq_push, oq_push;
    assign eq_pop  = req.rd && req.addr == `SES_A_ERRQ && eq.count != 4'h0;
    assign oq_pop  = req.rd && req.addr == `SES_A_OUTQ && oq.count != 4'h0;
    assign eq_push = err_push && eq.count != 4'(`SES_QDEPTH);
    assign oq_push = resp_push && oq.count != 4'(`SES_QDEPTH);
    // Error queue pointers; push into full queue dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eq <= '0;
        end else if (errclr) begin
            eq <= '0;
        end else begin
            eq.wptr  <= eq.wptr + 3'(eq_push);
            eq.rptr  <= eq.rptr + 3'(eq_pop);
            eq.count <= eq.count + 4'(eq_push) - 4'(eq_pop);
        end
    end
    // Output queue pointers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oq <= '0;
        end else begin
            oq.wptr  <= oq.wptr + 3'(oq_push);
            oq.rptr  <= oq.rptr + 3'(oq_pop);
            oq.count <= oq.count + 4'(oq_push) - 4'(oq_pop);
        end
    end
    // Queue storage
    always_ff @(posedge hclk) begin
        if (eq_push && !errclr) begin
            eq_mem[eq.wptr] <= err_code;
        end
        if (oq_push) begin
            oq_mem[oq.wptr] <= resp_data;
        end
    end
    // ----------------------------------------------------------------
    // Status byte and service request
    // ----------------------------------------------------------------
    logic [7:0] sre, sum_bits;
    logic       mss, req_flag, mss_q, poll;
    // Summary bits placed per position
    always_comb begin
        sum_bits = 8'h00;
        sum_bits[`SES_SB_MEA] = set_sum[SES_MEA];
        sum_bits[`SES_SB_EAV] = eq.count != 4'h0;
        sum_bits[`SES_SB_QUE] = set_sum[SES_QUE];
        sum_bits[`SES_SB_MAV] = oq.count != 4'h0;
        sum_bits[`SES_SB_STD] = set_sum[SES_STD];
        sum_bits[`SES_SB_OPR] = set_sum[SES_OPR];
    end
    assign mss  = |(sum_bits & sre);
    assign poll = req.rd && req.addr == `SES_A_POLL;
    // Service request enable, bit 6 never enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sre <= 8'h00;
        end else if (req.wr && req.addr == `SES_A_SRE) begin
            sre <= hwdata[7:0] & 8'hBF;
        end
    end
    // Request flag set on rising master summary, cleared by poll
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mss_q    <= 1'b0;
            req_flag <= 1'b0;
        end else begin
            mss_q <= mss;
            if (mss && !mss_q) begin
                req_flag <= 1'b1;
            end else if (poll) begin
                req_flag <= 1'b0;
            end
        end
    end
    assign status_byte = sum_bits | {1'b0, mss, 6'h00};
    assign srq         = req_flag;
    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] next_rdata;
    // Plain binary read-back
    always_comb begin
        next_rdata = `SES_ZERO32;
        unique case (haddr[7:0])
            `SES_A_STD_COND: next_rdata = {16'h0000, cond_s2[15:0]};
            `SES_A_OPR_COND: next_rdata = {16'h0000, cond_s2[31:16]};
            `SES_A_MEA_COND: next_rdata = {16'h0000, cond_s2[47:32]};
            `SES_A_QUE_COND: next_rdata = {16'h0000, cond_s2[63:48]};
            `SES_A_STD_EVT:  next_rdata = {16'h0000, evt[0]};
            `SES_A_OPR_EVT:  next_rdata = {16'h0000, evt[1]};
            `SES_A_MEA_EVT:  next_rdata = {16'h0000, evt[2]};
            `SES_A_QUE_EVT:  next_rdata = {16'h0000, evt[3]};
            `SES_A_STD_ENA:  next_rdata = {16'h0000, ena[0]};
            `SES_A_OPR_ENA:  next_rdata = {16'h0000, ena[1]};
            `SES_A_MEA_ENA:  next_rdata = {16'h0000, ena[2]};
            `SES_A_QUE_ENA:  next_rdata = {16'h0000, ena[3]};
            `SES_A_STB:      next_rdata = {24'h00_0000, status_byte};
            `SES_A_POLL:     next_rdata = {24'h00_0000, sum_bits | {1'b0, req_flag, 6'h00}};
            `SES_A_SRE:      next_rdata = {24'h00_0000, sre};
            `SES_A_ERRQ:     next_rdata = {16'h0000, eq.count != 4'h0 ? eq_mem[eq.rptr] : 16'h0000};
            `SES_A_OUTQ:     next_rdata = {16'h0000, oq.count != 4'h0 ? oq_mem[oq.rptr] : 16'h0000};
            `SES_A_LEVEL:    next_rdata = {24'h00_0000, oq.count, eq.count};
            default:         next_rdata = `SES_ZERO32;
        endcase
    end
    // Read data registered at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `SES_ZERO32;
        end else if (acc && !hwrite) begin
            hrdata <= next_rdata;
        end
    end
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_evt_latch: assert property (@(posedge hclk) disable iff (!hresetn)
        evt_set[16] |=> evt[1][0]) else $error("event bit not latched");
    a_cls_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        cls && evt_set == 64'h0 |=> evt[0] == 16'h0 && eq.count == 4'h0) else $error("clear status failed");
    a_preset_ena: assert property (@(posedge hclk) disable iff (!hresetn)
        preset |=> ena[1] == 16'h0 && ena[0] == $past(ena[0])) else $error("preset wrong");
    a_preset_queue: assert property (@(posedge hclk) disable iff (!hresetn)
        preset && !errclr && !eq_push && !eq_pop |=> $stable(eq.count)) else $error("preset touched queue");
    a_sum_eav: assert property (@(posedge hclk) disable iff (!hresetn)
        status_byte[`SES_SB_EAV] == (eq.count != 4'h0)) else $error("error available wrong");
    a_sum_std: assert property (@(posedge hclk) disable iff (!hresetn)
        status_byte[`SES_SB_STD] == |(evt[0] & ena[0])) else $error("standard summary wrong");
    a_mss_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        status_byte[`SES_SB_REQ] == |(status_byte & sre & 8'hBF)) else $error("master summary wrong");
    a_poll_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        poll && !(mss && !mss_q) |=> !srq) else $error("poll did not clear request");
    a_evt_read: assert property (@(posedge hclk) disable iff (!hresetn)
        req.rd && req.addr == `SES_A_OPR_EVT && evt_set[31:16] == 16'h0 |=> evt[1] == 16'h0)
        else $error("read did not clear event");
endmodule
`default_nettype wire

// ===== bench/ses_instr_model.sv
`default_nettype none
module ses_instr_model (
    // Clock
    input  wire logic        hclk,
    // Instrument lines
    output logic [63:0]      cond_in,
    output logic [63:0]      evt_pulse,
    output logic             err_push,
    output logic [15:0]      err_code,
    output logic             resp_push,
    output logic [15:0]      resp_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet lines at time zero
    initial begin
        cond_in   = 64'h0;
        evt_pulse = 64'h0;
        err_push  = 1'b0;
        resp_push = 1'b0;
        err_code  = 16'hFFFF;
        resp_data = 16'hFFFF;
    end
    // Drive the measurement condition levels from one place
    task automatic set_mea(input logic [15:0] val);
        @(posedge hclk);
        cond_in[47:32] <= val;
    endtask
    // Pulse one event line long enough to pass the synchronizer
    task automatic fire(input int b);
        @(posedge hclk);
        evt_pulse[b] <= 1'b1;
        repeat (2) @(posedge hclk);
        evt_pulse[b] <= 1'b0;
        repeat (5) @(posedge hclk);
    endtask
    // One-cycle push, error queue when q is high; data lines scrambled after
    task automatic push(input logic q, input logic [15:0] v);
        @(posedge hclk);
        err_push  <= q;
        resp_push <= !q;
        err_code  <= v;
        resp_data <= v;
        @(posedge hclk);
        err_push  <= 1'b0;
        resp_push <= 1'b0;
        err_code  <= ~v;
        resp_data <= ~v;
    endtask
endmodule
`default_nettype wire

// ===== bench/status_event_summary_tb_top.sv
`include "ses_defs.svh"
`default_nettype none
module status_event_summary_tb_top;
    import ses_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, srq;
    logic        err_push, resp_push;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  status_byte;
    logic [15:0] err_code, resp_data;
    logic [31:0] haddr, hwdata, hrdata, v, q, std_ena;
    logic [63:0] cond_in, evt_pulse;
    int          err_total, n_checks, k;
    assign hready = hreadyout;
    ses_status ses_status_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cond_in(cond_in), .evt_pulse(evt_pulse), .err_push(err_push), .err_code(err_code),
        .resp_push(resp_push), .resp_data(resp_data), .status_byte(status_byte), .srq(srq));
    ses_instr_model ses_instr_model_i (.hclk(hclk), .cond_in(cond_in), .evt_pulse(evt_pulse),
        .err_push(err_push), .err_code(err_code), .resp_push(resp_push), .resp_data(resp_data));
    // Clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB-Lite word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Status byte checked mid-cycle once updates have landed
    task automatic sbc(input logic [7:0] e);
        @(negedge hclk);
        chk({24'h0, status_byte}, {24'h0, e});
    endtask
    task automatic summarize();
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #200us;
        err_total++;
        summarize();
    end
    // Main sequence
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata} = '0;
        hsel  = 1'b1;
        hsize = 3'h2;
        v = $urandom(75192);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(`SES_A_STB, 32'h0);
        rdc(`SES_A_LEVEL, 32'h0);
        for (int s = 0; s < 4; s++) begin
            v = $urandom() & 32'h0000_FFFF;
            wr(8'h08 + 8'(s * 16), v);
            rdc(8'h08 + 8'(s * 16), v);
            if (s == 0) std_ena = v;
        end
        wr(`SES_A_MEA_COND, 32'h0000_FFFF);
        rdc(`SES_A_MEA_COND, 32'h0);
        v = $urandom() & 32'h0000_FFFF;
        ses_instr_model_i.set_mea(v[15:0]);
        repeat (4) @(posedge hclk);
        rdc(`SES_A_MEA_COND, v);
        ses_instr_model_i.set_mea(16'h0000);
        k = $urandom_range(15, 0);
        wr(`SES_A_OPR_ENA, 32'h1 << k);
        wr(`SES_A_MEA_ENA, 32'h0);
        wr(`SES_A_QUE_ENA, 32'h0);
        wr(`SES_A_SRE, 32'h0000_00FF);
        ses_instr_model_i.fire(16 + k);
        sbc(8'hC0);
        chk({31'h0, srq}, 32'h1);
        rdc(`SES_A_POLL, 32'h0000_00C0);
        sbc(8'hC0);
        chk({31'h0, srq}, 32'h0);
        rdc(`SES_A_OPR_EVT, 32'h1 << k);
        sbc(8'h00);
        ses_instr_model_i.push(1'b1, 16'h0A01);
        ses_instr_model_i.push(1'b1, 16'h0A02);
        ses_instr_model_i.push(1'b0, 16'h5555);
        sbc(8'h54);
        rdc(`SES_A_LEVEL, 32'h12);
        rdc(`SES_A_ERRQ, 32'h0A01);
        wr(`SES_A_CMD, 32'h8);
        rdc(`SES_A_LEVEL, 32'h11);
        rdc(`SES_A_OPR_ENA, 32'h1 << k);
        wr(`SES_A_CMD, 32'h2);
        rdc(`SES_A_OPR_ENA, 32'h0);
        rdc(`SES_A_STD_ENA, std_ena);
        rdc(`SES_A_LEVEL, 32'h11);
        k = $urandom_range(15, 0);
        ses_instr_model_i.fire(k);
        wr(`SES_A_CMD, 32'h1);
        rdc(`SES_A_STD_EVT, 32'h0);
        rdc(`SES_A_LEVEL, 32'h10);
        rdc(`SES_A_STD_ENA, std_ena);
        rdc(`SES_A_OUTQ, 32'h5555);
        wr(`SES_A_STD_ENA, 32'h0);
        rdc(`SES_A_STD_ENA, 32'h0);
        ses_instr_model_i.push(1'b1, 16'h0B03);
        wr(`SES_A_CMD, 32'h4);
        rdc(`SES_A_LEVEL, 32'h0);
        sbc(8'h00);
        summarize();
    end
endmodule
`default_nettype wire
